// ===== aca_defs.svh
`ifndef ACA_DEFS_SVH
`define ACA_DEFS_SVH

// status bit positions
`define ACA_ST_BUSY     7
`define ACA_ST_RDY      6
`define ACA_ST_DSC      4
`define ACA_ST_DRQ      3
`define ACA_ST_ERR      0
// drive/head fields
`define ACA_DH_LBA      6
`define ACA_DH_DRV      4
// command codes
`define ACA_CMD_PWR_A   8'hE5
`define ACA_CMD_PWR_B   8'h98
`define ACA_CMD_DIAG    8'h90
`define ACA_CMD_ERASE   8'hC0
`define ACA_CMD_FMT     8'h50
`define ACA_CMD_WBUF    8'hE8
`define ACA_CMD_WMUL    8'hC5
`define ACA_CMD_WMUL_NE 8'hCD
`define ACA_CMD_WSEC_NE 8'h38
`define ACA_CMD_WVER    8'h3C
`define ACA_CMD_SENSE   8'h03
`define ACA_CMD_XLATE   8'h87
`define ACA_CMD_WEAR    8'hF5
// result values
`define ACA_PWR_SLEEP   8'h00
`define ACA_PWR_IDLE    8'hFF
`define ACA_DIAG_OK     8'h01
`define ACA_DIAG_SLAVE  4'h8
`define ACA_ERR_ABORT   8'h04
// timing, as printed, and derived cycle counts at 50 MHz
`define ACA_CLK_NS      20
`define ACA_BUSY_NS     400
`define ACA_DRQ2_US     700
`define ACA_DRQ3_MS     20
`define ACA_BUSY_CYC    (`ACA_BUSY_NS / `ACA_CLK_NS)
`define ACA_DRQ2_CYC    (`ACA_DRQ2_US * 1000 / `ACA_CLK_NS)
`define ACA_DRQ3_CYC    (`ACA_DRQ3_MS * 1000000 / `ACA_CLK_NS)

`endif

// ===== aca_pkg.sv
package aca_pkg;

  typedef enum logic [1:0]
  {
    ACA_CLS_1   = 2'b00,
    ACA_CLS_2   = 2'b01,
    ACA_CLS_3   = 2'b10,
    ACA_CLS_BAD = 2'b11
  } aca_class_t;

  typedef enum logic [2:0]
  {
    ACA_IDLE  = 3'b000,
    ACA_EXEC  = 3'b001,
    ACA_PREP  = 3'b010,
    ACA_DRQ   = 3'b011,
    ACA_XFER  = 3'b100,
    ACA_DONE  = 3'b101
  } aca_state_t;

  // task-file parameters the host has loaded
  typedef struct packed
  {
    logic [7:0] feature_param_reg;
    logic [7:0] count_param_reg;
    logic [7:0] sector_index_param_reg;
    logic [15:0] cylinder_param_regs;
    logic [7:0] drive_head_select_reg;
  } aca_taskfile_t;

  // parameters latched for the back end
  typedef struct packed
  {
    logic        lba_mode;
    logic        drive;
    logic [3:0]  head;
    logic [7:0]  count;
    logic [7:0]  sector;
    logic [15:0] cylinder;
    logic [7:0]  feature;
  } aca_params_t;

endpackage

// ===== aca_core.sv
`timescale 1ns/1ns
`include "aca_defs.svh"

// Contract
// R1: host loads parameter registers before writing the command code.
// R2: host issues commands only while busy_flag reads clear.
// R3: class one command raises busy within 400 ns of code write.
// R4: class two: busy fast, buffer ready, DRQ within 700 us, then busy drops.
// R5: class three: busy fast, DRQ within 20 ms, busy drops shortly after.
// R6: only task-file registers marked for a command become parameters; the code latches count, sector, cylinder and feature for every command.
// R7: drive-only commands use the drive bit and ignore head bits.
// R8: codes E5h and 98h both query power mode.
// R9: power query when sleeping loads 00h into count, clears busy, interrupts.
// R10: power query when idle loads FFh into count, clears busy, interrupts.
// R11: code 90h runs internal self-diagnostics.
// R12: diagnostics end by placing a result code in the error register.
// R13: results: 01h ok, 02h..05h formatter, buffer, ECC, processor faults.
// R14: failed second drive reports upper nibble 8 in the diagnostic result.
// R15: code CDh is a class three multi-sector write without pre-erase.
// R16: code 38h is a class two sector write without pre-erase.
// R17: legacy erase and no-erase writes still erase and complete normally.
// R18: vendor commands sense, translate and wear level are executed.
// R19: drive/head bit 6 selects CHS when 0, LBA when 1.
// R20: busy is status bit 7; other status bits invalid while set.
// R21: DRQ is status bit 3, set when data must move.
// R22: unknown command codes end with the error flag set.
module aca_core
#(
  parameter int unsigned DRQ3_CYCLES = `ACA_DRQ3_CYC,
  parameter int unsigned BUSY_CYCLES = `ACA_BUSY_CYC
)
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire aca_pkg::aca_taskfile_t taskfile,
  input  wire logic                  cmd_wr,
  input  wire logic [7:0]            cmd_code,
  input  wire logic                  sleep_state,
  input  wire logic                  buf_ready,
  input  wire logic                  xfer_done,
  input  wire logic                  diag_done,
  input  wire logic [3:0]            diag_fault,
  input  wire logic                  slave_failed,
  input  wire logic                  exec_done,
  output logic [7:0]                 status,
  output logic [7:0]                 error_reg,
  output logic [7:0]                 count_out,
  output logic                       count_load,
  output logic                       intrq,
  output logic                       buf_prep,
  output logic                       exec_start,
  output logic [7:0]                 exec_code,
  output aca_pkg::aca_params_t       params,
  output logic                       diag_start
);
  import aca_pkg::*;

  localparam int unsigned DRQ2_CYCLES = `ACA_DRQ2_CYC;
  localparam int TW = 24;

  // classify a code; also used to check whether it is known
  function automatic aca_class_t cls_of(input logic [7:0] c);
    if (c == `ACA_CMD_WMUL ||
        c == `ACA_CMD_WMUL_NE)
      cls_of = ACA_CLS_3;                                   // see R15
    else if (c[7:1] == 7'h18 ||
             c == `ACA_CMD_WSEC_NE ||
             c == `ACA_CMD_WVER ||
             c[7:1] == 7'h19 ||
             c == `ACA_CMD_FMT ||
             c == `ACA_CMD_WBUF)
      cls_of = ACA_CLS_2;                                   // see R16
    else if (c == `ACA_CMD_PWR_A ||
             c == `ACA_CMD_PWR_B ||
             c == `ACA_CMD_DIAG ||
             c == `ACA_CMD_ERASE ||
             c == 8'hEC ||
             c == 8'hE3 ||
             c == 8'h97 ||
             c == 8'hE1 ||
             c == 8'h95 ||
             c == 8'h91 ||
             c == 8'hE4 ||
             c == 8'hC4 ||
             c[7:1] == 7'h11 ||
             c[7:1] == 7'h10 ||
             c[7:1] == 7'h20 ||
             c[7:4] == 4'h1 ||
             c[7:4] == 4'h7 ||
             c == 8'hEF ||
             c == 8'hC6 ||
             c == 8'hE6 ||
             c == 8'h99 ||
             c == 8'hE2 ||
             c == 8'h96 ||
             c == 8'hE0 ||
             c == 8'h94 ||
             c == `ACA_CMD_SENSE ||
             c == `ACA_CMD_XLATE ||
             c == `ACA_CMD_WEAR)
      cls_of = ACA_CLS_1;                                   // see R18
    else
      cls_of = ACA_CLS_BAD;
  endfunction

  // head bits count only for commands marked with a full drive/head use
  function automatic logic uses_head(input logic [7:0] c);
    uses_head = !(c == `ACA_CMD_PWR_A ||
                  c == `ACA_CMD_PWR_B ||
                  c == `ACA_CMD_DIAG ||
                  c == 8'hEC ||
                  c == 8'hE3 ||
                  c == 8'h97 ||
                  c == 8'hE1 ||
                  c == 8'h95 ||
                  c == 8'hE4 ||
                  c[7:4] == 4'h1 ||
                  c == 8'hEF ||
                  c == 8'hC6 ||
                  c == 8'hE6 ||
                  c == 8'h99 ||
                  c == 8'hE2 ||
                  c == 8'h96 ||
                  c == 8'hE0 ||
                  c == 8'h94 ||
                  c == `ACA_CMD_SENSE ||
                  c == `ACA_CMD_WBUF);
  endfunction

  aca_state_t  state_q, state_d;
  aca_class_t  cls_q;
  logic [7:0]  code_q;
  logic [TW-1:0] tmr_q;
  logic        busy_q, drq_q, err_q, rdy_q;
  logic [7:0]  err_reg_q;
  logic [7:0]  count_q;
  logic        count_ld_q, intrq_q, diag_q, exec_q;
  aca_params_t params_q;

  wire aca_class_t new_cls   = cls_of(cmd_code);
  wire logic       accept    = (state_q == ACA_IDLE) && cmd_wr;  // see R2
  wire logic       is_pwr    = code_q == `ACA_CMD_PWR_A ||
                               code_q == `ACA_CMD_PWR_B;         // see R8
  wire logic       is_diag   = code_q == `ACA_CMD_DIAG;          // see R11
  // two short of the ceiling: drq shows only once busy drops, two edges on
  wire logic [TW-1:0] drq_lim = (cls_q == ACA_CLS_3) ?
                               TW'(DRQ3_CYCLES - 2) : TW'(DRQ2_CYCLES - 2);
  wire logic       tmo       = tmr_q >= drq_lim;
  wire logic       head_used = uses_head(cmd_code);
  // the diagnostic fault code; slave failure overrides with upper nibble 8
  wire logic [7:0] diag_code = slave_failed ?
                               {`ACA_DIAG_SLAVE, diag_fault} :   // see R14
                               ((diag_fault == 4'h0) ? `ACA_DIAG_OK :
                                {4'h0, diag_fault});             // see R13

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ACA_IDLE:
        if (accept)
          state_d = (new_cls == ACA_CLS_1) ? ACA_EXEC :
                    (new_cls == ACA_CLS_BAD) ? ACA_DONE : ACA_PREP;
      ACA_EXEC:
        if (is_pwr || (is_diag && diag_done) || (!is_diag && exec_done))
          state_d = ACA_DONE;
      ACA_PREP:
        // buffer not ready in time still raises DRQ; the limit is a ceiling
        if (buf_ready || tmo)
          state_d = ACA_DRQ;                                 // see R4 R5
      ACA_DRQ:
        state_d = ACA_XFER;
      ACA_XFER:
        if (xfer_done)
          state_d = ACA_DONE;                                // see R17
      ACA_DONE:
        state_d = ACA_IDLE;
      default:
        state_d = ACA_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ACA_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cls_q  <= ACA_CLS_1;
      code_q <= 8'h00;
      params_q <= '0;
    end
    else if (accept)
    begin
      cls_q  <= new_cls;
      code_q <= cmd_code;
      params_q.lba_mode <=                                  // see R19
        taskfile.drive_head_select_reg[`ACA_DH_LBA];
      params_q.drive    <=                                  // see R7
        taskfile.drive_head_select_reg[`ACA_DH_DRV];
      params_q.head     <= head_used ?                      // see R7
                           taskfile.drive_head_select_reg[3:0] : 4'h0;
      params_q.count    <= taskfile.count_param_reg;                 // see R6
      params_q.sector   <= taskfile.sector_index_param_reg;
      params_q.cylinder <= taskfile.cylinder_param_regs;
      params_q.feature  <= taskfile.feature_param_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tmr_q <= '0;
    else if (state_q != ACA_PREP)
      tmr_q <= '0;
    else
      tmr_q <= tmr_q + TW'(1);
  end

  // busy is set on the edge that takes the code: one cycle, within 400 ns
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      drq_q  <= 1'b0;
      rdy_q  <= 1'b0;
    end
    else
    begin
      rdy_q <= 1'b1;
      if (accept)
        busy_q <= 1'b1;                                      // see R3
      else if (state_q == ACA_DRQ || state_q == ACA_DONE)
        busy_q <= 1'b0;                                      // see R4 R5
      if (state_q == ACA_PREP && state_d == ACA_DRQ)
        drq_q <= 1'b1;                                       // see R21
      else if (state_q == ACA_XFER && xfer_done)
        drq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_q      <= 1'b0;
      err_reg_q  <= 8'h00;
      count_q    <= 8'h00;
      count_ld_q <= 1'b0;
      intrq_q    <= 1'b0;
    end
    else
    begin
      count_ld_q <= 1'b0;
      intrq_q    <= state_q == ACA_DONE;
      if (accept)
      begin
        err_q <= new_cls == ACA_CLS_BAD;                     // see R22
        err_reg_q <= (new_cls == ACA_CLS_BAD) ? `ACA_ERR_ABORT : 8'h00;
      end
      else if (state_q == ACA_EXEC && is_diag && diag_done)
      begin
        err_reg_q <= diag_code;                              // see R12
        err_q <= diag_code != `ACA_DIAG_OK;
      end
      if (state_q == ACA_EXEC && is_pwr)
      begin
        count_q <= sleep_state ? `ACA_PWR_SLEEP :           // see R9 R10
                                 `ACA_PWR_IDLE;
        count_ld_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      diag_q <= 1'b0;
      exec_q <= 1'b0;
    end
    else
    begin
      diag_q <= accept && cmd_code == `ACA_CMD_DIAG;
      exec_q <= accept && new_cls != ACA_CLS_BAD &&
                cmd_code != `ACA_CMD_PWR_A && cmd_code != `ACA_CMD_PWR_B &&
                cmd_code != `ACA_CMD_DIAG;
    end
  end

  // while busy only the busy bit is meaningful; others forced low
  assign status = busy_q ? 8'h80 :
                  (8'(rdy_q) << `ACA_ST_RDY) | (8'(rdy_q) << `ACA_ST_DSC) |
                  (8'(drq_q) << `ACA_ST_DRQ) | (8'(err_q) << `ACA_ST_ERR);
                                                             // see R20
  assign error_reg  = err_reg_q;
  assign count_out  = count_q;
  assign count_load = count_ld_q;
  assign intrq      = intrq_q;                               // see R9 R10
  assign buf_prep   = state_q == ACA_PREP;
  assign exec_start = exec_q;
  assign exec_code  = code_q;
  assign params     = params_q;
  assign diag_start = diag_q;

endmodule

// ===== aca_chk.sv
`timescale 1ns/1ns
module aca_chk
#(
  parameter int unsigned DRQ3_CYCLES = 50
)
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic       sleep_state,
  input wire logic       buf_ready,
  input wire logic       diag_done,
  input wire logic [3:0] diag_fault,
  input wire logic       slave_failed,
  input wire logic [7:0] status,
  input wire logic [7:0] error_reg,
  input wire logic [7:0] count_out,
  input wire logic       count_load,
  input wire logic       intrq,
  input wire logic       buf_prep,
  input wire logic       diag_start
);
  localparam int LIM3 = DRQ3_CYCLES + 1;
  logic open_q;
  logic acc;
  logic pwr;
  // own tracking of an open command, so a slip in the idle test shows
  assign acc = cmd_wr && !status[7] && !open_q;
  assign pwr = acc && (cmd_code == 8'hE5 || cmd_code == 8'h98);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      open_q <= 1'b0;
    else if (acc)
      open_q <= 1'b1;
    else if (intrq)
      open_q <= 1'b0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_pwr_tail;
    status[7] ##1 count_load ##1 (!status[7] && intrq);
  endsequence
  property p_busy;
    acc |=> status == 8'h80;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_pwr_slp;
    pwr && sleep_state |-> ##2 count_load && count_out == 8'h00;
  endproperty
  a_pwr_slp: assert property (p_pwr_slp) else $error("sleep count");
  property p_pwr_idle;
    pwr && !sleep_state |-> ##2 count_load && count_out == 8'hFF;
  endproperty
  a_pwr_idle: assert property (p_pwr_idle) else $error("idle count");
  property p_pwr_seq;
    pwr |=> s_pwr_tail;
  endproperty
  a_pwr_seq: assert property (p_pwr_seq) else $error("power steps");
  property p_diag;
    acc && cmd_code == 8'h90 |=> diag_start;
  endproperty
  a_diag: assert property (p_diag) else $error("no diag start");
  // fault code is held by the driver until the command ends
  property p_diag_res;
    diag_done |-> ##[1:4] error_reg == (slave_failed ? {4'h8, diag_fault}
      : (diag_fault == 4'h0 ? 8'h01 : {4'h0, diag_fault}));
  endproperty
  a_diag_res: assert property (p_diag_res) else $error("diag code");
  property p_bad;
    acc && cmd_code == 8'hFF |-> ##[2:3] (status[0] && error_reg == 8'h04);
  endproperty
  a_bad: assert property (p_bad) else $error("bad code not aborted");
  property p_prep;
    acc && (cmd_code == 8'h30 || cmd_code == 8'h38 || cmd_code == 8'hCD)
      |=> buf_prep && status[7];
  endproperty
  a_prep: assert property (p_prep) else $error("no buffer prep");
  property p_drq;
    buf_prep && buf_ready |-> ##[1:20] (status[3] && !status[7]);
  endproperty
  a_drq: assert property (p_drq) else $error("drq late");
  property p_cls3;
    acc && cmd_code == 8'hCD |-> ##[1:LIM3] status[3];
  endproperty
  a_cls3: assert property (p_cls3) else $error("class three late");
endmodule

bind aca_core aca_chk #(.DRQ3_CYCLES(DRQ3_CYCLES)) u_aca_chk (.clk, .rst_b,
  .cmd_wr, .cmd_code, .sleep_state, .buf_ready, .diag_done, .diag_fault,
  .slave_failed, .status, .error_reg, .count_out, .count_load, .intrq,
  .buf_prep, .diag_start);

// ===== aca_host.sv
`timescale 1ns/1ns
module aca_host
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   go,
  input  wire logic [7:0]             go_code,
  input  wire aca_pkg::aca_taskfile_t go_tf,
  input  wire logic [7:0]             status,
  output logic                        cmd_wr,
  output logic [7:0]                  cmd_code,
  output aca_pkg::aca_taskfile_t      taskfile
);
  import aca_pkg::*;
  logic       pend_q;
  logic [7:0] code_q;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pend_q <= 1'b0;
      code_q <= 8'h00;
      cmd_wr <= 1'b0;
      cmd_code <= 8'hFF;
      taskfile <= '0;
    end
    else if (go)
    begin
      taskfile <= go_tf;
      code_q <= go_code;
      pend_q <= 1'b1;
      cmd_wr <= 1'b0;
    end
    else if (pend_q && !status[7])
    begin
      cmd_wr <= 1'b1;
      cmd_code <= code_q;
      pend_q <= 1'b0;
    end
    else
    begin
      cmd_wr <= 1'b0;
      cmd_code <= ~code_q; // code lines carry no stale value
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  import aca_pkg::*;
  logic clk = 0, rst_b = 0, go = 0, sleep_state = 0, buf_ready = 0;
  logic xfer_done = 0, diag_done = 0, slave_failed = 0, exec_done = 0;
  logic [3:0] diag_fault = 4'h0;
  logic [7:0] go_code = 8'h00;
  aca_taskfile_t go_tf = '0;
  logic cmd_wr, count_load, intrq, buf_prep, exec_start, diag_start;
  logic [7:0] cmd_code, status, error_reg, count_out, exec_code;
  aca_taskfile_t taskfile;
  aca_params_t params;
  int num_errors = 0, num_checks = 0;
  aca_host u_aca_host (.clk, .rst_b, .go, .go_code, .go_tf, .status,
    .cmd_wr, .cmd_code, .taskfile);
  aca_core #(.DRQ3_CYCLES(50)) u_aca_core (.clk, .rst_b, .taskfile, .cmd_wr,
    .cmd_code, .sleep_state, .buf_ready, .xfer_done, .diag_done,
    .diag_fault, .slave_failed, .exec_done, .status, .error_reg,
    .count_out, .count_load, .intrq, .buf_prep, .exec_start, .exec_code,
    .params, .diag_start);
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // returns at the edge that takes the command
  task automatic issue(input logic [7:0] c, input logic [7:0] dh);
    int n;
    n = 0;
    go <= 1'b1;
    go_code <= c;
    go_tf <= {8'h11, 8'h22, 8'h33, 16'h4455, dh};
    @(posedge clk);
    go <= 1'b0;
    do
    begin
      @(posedge clk);
      if (++n > 20)
      begin
        num_errors++;
        end_of_test;
      end
    end while (cmd_wr !== 1'b1);
  endtask
  task automatic wait_for(input int lim, input int sel);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      if (++n > lim)
      begin
        num_errors++;
        end_of_test;
      end
    end while ((sel ? status[3] : intrq) !== 1'b1);
  endtask
  task automatic s_pwr;
    logic [7:0] c [2] = '{8'hE5, 8'h98};
    for (int s = 0; s < 2; s++)
      foreach (c[i])
      begin
        sleep_state <= s[0];
        issue(c[i], 8'hFF);
        @(posedge clk);
        chk(status, 8'h80);
        @(posedge clk);
        chk({count_load, count_out}, s ? 9'h100 : 9'h1FF);
        @(posedge clk);
        chk(status[7], 1'h0);
        chk(intrq, 1'h1);
        chk({params.drive, params.head}, 5'h10);
      end
  endtask
  task automatic s_diag;
    logic [4:0] f [6] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h13};
    foreach (f[i])
    begin
      diag_fault <= f[i][3:0];
      slave_failed <= f[i][4];
      issue(8'h90, 8'hA0);
      @(posedge clk);
      chk(diag_start, 1'h1);
      diag_done <= 1'b1;
      @(posedge clk);
      diag_done <= 1'b0;
      wait_for(10, 0);
      chk(error_reg, f[i][4] ? {4'h8, f[i][3:0]} : (f[i] == 5'h00 ?
        8'h01 : {4'h0, f[i][3:0]}));
    end
  endtask
  // odd entries get no buffer-ready, so the time limit is what raises drq
  task automatic s_wr;
    logic [7:0] c [4] = '{8'h30, 8'h38, 8'hC5, 8'hCD};
    foreach (c[i])
    begin
      issue(c[i], 8'hEA);
      @(posedge clk);
      chk({status, buf_prep}, 9'h101);
      if (!i[0]) buf_ready <= 1'b1;
      @(posedge clk);
      buf_ready <= 1'b0;
      wait_for(i == 1 ? 34999 : 49, 1);
      chk(status[7], 1'h0);
      chk({params.lba_mode, params.head}, 5'h1A);
      chk({params.count, params.sector, params.cylinder}, 32'h22334455);
      xfer_done <= 1'b1;
      @(posedge clk);
      xfer_done <= 1'b0;
      wait_for(10, 0);
      chk(status[3], 1'h0);
    end
  endtask
  task automatic s_exec;
    logic [7:0] c [6] = '{8'h20, 8'hC0, 8'h03, 8'h87, 8'hF5, 8'hFF};
    foreach (c[i])
    begin
      issue(c[i], 8'hE5);
      @(posedge clk);
      if (c[i] != 8'hFF)
      begin
        chk({exec_start, exec_code}, {1'h1, c[i]});
        exec_done <= 1'b1;
        @(posedge clk);
        exec_done <= 1'b0;
      end
      wait_for(10, 0);
      chk({status[0], error_reg}, c[i] == 8'hFF ? 9'h104 : 9'h000);
      chk(status, c[i] == 8'hFF ? 8'h51 : 8'h50);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    s_pwr;
    s_diag;
    s_wr;
    s_exec;
    end_of_test;
  end
endmodule
